// File: uhcs_pkg.sv
// uhcs_pkg: constants and carriers for the host operating control block
// assumes a 32-bit APB slave on a 250 MHz clock
package uhcs_pkg;

  // register map, byte addresses on the APB
  localparam logic [7:0]  CTRL_RD_CODE   = 8'h01;
  localparam logic [7:0]  CTRL_WR_CODE   = 8'h81;
  localparam logic [11:0] ADDR_CTRL      = 12'h004;
  localparam logic [11:0] ADDR_EVENTS    = 12'h008;
  localparam logic [11:0] ADDR_SWRESET   = 12'h00C;

  // field positions in host_operating_control
  localparam int          RWE_BIT        = 10;
  localparam int          RWC_BIT        = 9;
  localparam int          FS_LSB         = 6;

  // bits in the events register
  localparam int          EV_RESUME_BIT  = 0;
  localparam int          EV_SOF_BIT     = 1;

  // reset values
  localparam logic        RWE_RESET      = 1'b0;
  localparam logic        RWC_RESET      = 1'b0;

  // timing
  localparam int          CLK_MHZ        = 250;
  localparam int          SOF_DELAY_US   = 1000;
  localparam int          SOF_DELAY_CYC  = SOF_DELAY_US * CLK_MHZ;
  localparam int          HUB_RST_CYC    = 16;

  typedef enum logic [1:0] {
    UHCS_BUS_RESET   = 2'b00,
    UHCS_BUS_RESUME  = 2'b01,
    UHCS_OPERATIONAL = 2'b10,
    UHCS_SUSPENDED   = 2'b11
  } uhcs_state_t;

  typedef struct packed {
    logic        remote_wakeup_enable;
    logic        remote_wakeup_connected;
    uhcs_state_t functional_state;
  } uhcs_ctrl_t;

endpackage

// File: uhcs_top.sv
// uhcs_top: host operating control register, state field and SOF start timer
// assumes APB master on the same clock; resume pin arrives asynchronously
//
// Local design decisions: the address map and register access over APB.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// [RQ1] wake-up signalled when wake-up enable and resume flag both set
// [RQ2] wake-up enable never gates the interrupt output
// [RQ3] firmware sets wake-up connected during power-on self test
// [RQ4] hardware reset clears wake-up connected; software reset keeps it
// [RQ5] state codes: 00 reset, 01 resume, 10 operational, 11 suspend
// [RQ6] entering operational starts SOF generation 1 ms later
// [RQ7] SOF start is shown by the frame start flag
// [RQ8] hardware changes the state field only while in suspend
// [RQ9] suspend moves to resume on downstream resume signalling
// [RQ10] software or hardware reset puts the state in bus reset
// [RQ11] hardware reset also resets the root hub and drives bus reset
// [RQ12] register read with code 01h, written with code 81h
// [RQ13] only the driver writes wake-up enable
// [RQ14] reserved bits ignore writes and read as zero
module uhcs_top #(
  parameter int SOF_DELAY = uhcs_pkg::SOF_DELAY_CYC
) (
  // clock and reset
  input  wire logic        I_REF_CLK,
  input  wire logic        I_RESETN,
  // apb slave
  input  wire logic        I_PSEL,
  input  wire logic        I_PENABLE,
  input  wire logic        I_PWRITE,
  input  wire logic [11:0] I_PADDR,
  input  wire logic [31:0] I_PWDATA,
  output logic      [31:0] O_PRDATA,
  output logic             O_PREADY,
  output logic             O_PSLVERR,
  // downstream and interrupt side
  input  wire logic        I_RESUME_DETECT,
  input  wire logic        I_IRQ_EVENT,
  output logic             O_IRQ,
  output logic             O_REMOTE_WAKEUP,
  output logic             O_SOF_ENABLE,
  output logic             O_ROOT_HUB_RESET,
  output logic      [1:0]  O_FUNCTIONAL_STATE
);

  uhcs_pkg::uhcs_ctrl_t ctrl;
  logic                 resume_meta;
  logic                 resume_sync;
  logic                 resume_prev;
  logic                 resume_rise;
  logic                 resume_flag;
  logic                 frame_start_flag;
  logic [31:0]          sof_cnt;
  logic                 sof_running;
  logic [4:0]           hub_cnt;
  logic                 wr_en;
  logic                 rd_ok;
  logic                 sw_reset;
  logic                 ctrl_wr;
  logic                 ev_wr;
  uhcs_pkg::uhcs_state_t prev_state;
  uhcs_pkg::uhcs_state_t wr_state;

  // single-cycle access: zero wait states keeps the slave trivial
  assign O_PREADY  = 1'b1;
  assign wr_en     = I_PSEL && I_PENABLE && I_PWRITE;
  assign rd_ok     = (I_PADDR == uhcs_pkg::ADDR_CTRL) || (I_PADDR == uhcs_pkg::ADDR_EVENTS)
                     || (I_PADDR == uhcs_pkg::ADDR_SWRESET);
  assign O_PSLVERR = I_PSEL && I_PENABLE && !rd_ok;
  // [RQ12] control read and write decode
  assign ctrl_wr   = wr_en && (I_PADDR == uhcs_pkg::ADDR_CTRL);
  assign ev_wr     = wr_en && (I_PADDR == uhcs_pkg::ADDR_EVENTS);
  assign sw_reset  = wr_en && (I_PADDR == uhcs_pkg::ADDR_SWRESET) && I_PWDATA[0];
  assign wr_state  = uhcs_pkg::uhcs_state_t'(I_PWDATA[uhcs_pkg::FS_LSB +: 2]);

  // two-flop synchroniser; only the second stage feeds logic
  always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      resume_meta <= 1'b0;
      resume_sync <= 1'b0;
      resume_prev <= 1'b0;
    end else begin
      resume_meta <= I_RESUME_DETECT;
      resume_sync <= resume_meta;
      resume_prev <= resume_sync;
    end
  end
  assign resume_rise = resume_sync && !resume_prev;

  // [RQ4] connected bit: hardware reset only
  always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      ctrl.remote_wakeup_connected <= uhcs_pkg::RWC_RESET;
    end else if (ctrl_wr) begin
      ctrl.remote_wakeup_connected <= I_PWDATA[uhcs_pkg::RWC_BIT];
    end
  end

  // [RQ13] enable bit changed by driver writes alone
  always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      ctrl.remote_wakeup_enable <= uhcs_pkg::RWE_RESET;
    end else if (sw_reset) begin
      ctrl.remote_wakeup_enable <= uhcs_pkg::RWE_RESET;
    end else if (ctrl_wr) begin
      ctrl.remote_wakeup_enable <= I_PWDATA[uhcs_pkg::RWE_BIT];
    end
  end

  // [RQ10] both resets force bus reset state
  always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      ctrl.functional_state <= uhcs_pkg::UHCS_BUS_RESET;
    end else if (sw_reset) begin
      ctrl.functional_state <= uhcs_pkg::UHCS_BUS_RESET;
    end else if (ctrl_wr) begin
      ctrl.functional_state <= wr_state;
    // [RQ8] [RQ9] autonomous move only out of suspend
    end else if (ctrl.functional_state == uhcs_pkg::UHCS_SUSPENDED && resume_rise) begin
      ctrl.functional_state <= uhcs_pkg::UHCS_BUS_RESUME;
    end
  end

  // [RQ6] 1 ms timer from entry into operational
  always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      prev_state  <= uhcs_pkg::UHCS_BUS_RESET;
      sof_cnt     <= 32'h00000000;
      sof_running <= 1'b0;
    end else begin
      prev_state <= ctrl.functional_state;
      if (ctrl.functional_state != uhcs_pkg::UHCS_OPERATIONAL) begin
        sof_cnt     <= 32'h00000000;
        sof_running <= 1'b0;
      end else if (prev_state != uhcs_pkg::UHCS_OPERATIONAL) begin
        sof_cnt     <= 32'h00000001;
      end else if (!sof_running) begin
        if (sof_cnt >= 32'(SOF_DELAY)) begin
          sof_running <= 1'b1;
        end else begin
          sof_cnt <= sof_cnt + 32'h00000001;
        end
      end
    end
  end
  assign O_SOF_ENABLE = sof_running;

  // [RQ7] sticky frame start and resume flags; set wins over clear
  always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      frame_start_flag <= 1'b0;
      resume_flag      <= 1'b0;
    end else begin
      if (sof_cnt == 32'(SOF_DELAY) && !sof_running &&
          ctrl.functional_state == uhcs_pkg::UHCS_OPERATIONAL) begin
        frame_start_flag <= 1'b1;
      end else if (ev_wr && I_PWDATA[uhcs_pkg::EV_SOF_BIT]) begin
        frame_start_flag <= 1'b0;
      end
      if (resume_rise && ctrl.functional_state == uhcs_pkg::UHCS_SUSPENDED) begin
        resume_flag <= 1'b1;
      end else if (ev_wr && I_PWDATA[uhcs_pkg::EV_RESUME_BIT]) begin
        resume_flag <= 1'b0;
      end
    end
  end

  // [RQ11] root hub reset pulse after hardware reset
  always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      hub_cnt <= 5'h00;
    end else if (hub_cnt != 5'(uhcs_pkg::HUB_RST_CYC)) begin
      hub_cnt <= hub_cnt + 5'h01;
    end
  end
  assign O_ROOT_HUB_RESET = (hub_cnt != 5'(uhcs_pkg::HUB_RST_CYC));

  // [RQ1] wake-up signal
  assign O_REMOTE_WAKEUP = ctrl.remote_wakeup_enable && resume_flag;
  // [RQ2] interrupt independent of wake-up enable
  assign O_IRQ = I_IRQ_EVENT || resume_flag || frame_start_flag;
  assign O_FUNCTIONAL_STATE = ctrl.functional_state;

  // [RQ14] [RQ5] read mux, reserved bits zero
  always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      O_PRDATA <= 32'h00000000;
    end else if (I_PSEL && !I_PENABLE && !I_PWRITE) begin
      O_PRDATA <= 32'h00000000;
      if (I_PADDR == uhcs_pkg::ADDR_CTRL) begin
        O_PRDATA[uhcs_pkg::RWE_BIT]          <= ctrl.remote_wakeup_enable;
        O_PRDATA[uhcs_pkg::RWC_BIT]          <= ctrl.remote_wakeup_connected;
        O_PRDATA[uhcs_pkg::FS_LSB +: 2]      <= ctrl.functional_state;
      end else if (I_PADDR == uhcs_pkg::ADDR_EVENTS) begin
        O_PRDATA[uhcs_pkg::EV_RESUME_BIT]    <= resume_flag;
        O_PRDATA[uhcs_pkg::EV_SOF_BIT]       <= frame_start_flag;
      end
    end
  end

  // [RQ4] connected bit survives software reset
  chk_rwc_sw_keep: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
    sw_reset && !ctrl_wr |=> $stable(ctrl.remote_wakeup_connected))
    else $error("connected bit changed by software reset");

  // [RQ10] software reset forces bus reset
  chk_swrst_state: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
    sw_reset |=> ctrl.functional_state == uhcs_pkg::UHCS_BUS_RESET)
    else $error("state not bus reset after software reset");

  // [RQ8] no autonomous change outside suspend
  chk_state_hold: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
    !ctrl_wr && !sw_reset && ctrl.functional_state != uhcs_pkg::UHCS_SUSPENDED
    |=> $stable(ctrl.functional_state))
    else $error("state changed without write");

  // [RQ9] resume taken from suspend
  chk_suspend_res: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
    resume_rise && !ctrl_wr && !sw_reset && ctrl.functional_state == uhcs_pkg::UHCS_SUSPENDED
    |=> ctrl.functional_state == uhcs_pkg::UHCS_BUS_RESUME)
    else $error("suspend did not move to resume");

  // [RQ13] enable bit stable without writes
  chk_rwe_stable: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
    !ctrl_wr && !sw_reset |=> $stable(ctrl.remote_wakeup_enable))
    else $error("wake-up enable changed by itself");

  // [RQ1] wake-up follows its causes
  chk_wakeup_out: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
    O_REMOTE_WAKEUP == (ctrl.remote_wakeup_enable && resume_flag))
    else $error("wake-up output wrong");

  // [RQ2] interrupt unaffected by enable
  chk_irq_indep: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
    resume_flag |-> O_IRQ)
    else $error("interrupt missing with resume flag");

  // [RQ6] no SOF before entry delay
  chk_sof_delay: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
    $rose(sof_running) |-> sof_cnt == 32'(SOF_DELAY))
    else $error("sof started at wrong count");

  // [RQ7] flag raised when SOF starts
  chk_sof_flag: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
    $rose(sof_running) |-> frame_start_flag)
    else $error("frame start flag not set");

  // [RQ11] hub reset lasts its count
  chk_hub_reset: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
    $fell(O_ROOT_HUB_RESET) |-> hub_cnt == 5'(uhcs_pkg::HUB_RST_CYC))
    else $error("hub reset length wrong");

  // [RQ14] reserved bits of control read zero, bit 8 left unchecked
  chk_rsvd_zero: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
    $past(I_PSEL && !I_PENABLE && !I_PWRITE && I_PADDR == uhcs_pkg::ADDR_CTRL)
    |-> (O_PRDATA & 32'hFFFFF83F) == 32'h00000000)
    else $error("reserved bits not zero");

  // [RQ14] reserved bits of events read zero
  chk_rsvd_events: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN) // [RQ14]
    $past(I_PSEL && !I_PENABLE && !I_PWRITE && I_PADDR == uhcs_pkg::ADDR_EVENTS)
    |-> (O_PRDATA & 32'hFFFFFFFC) == 32'h00000000)
    else $error("reserved event bits not zero");

  // [RQ5] state field read back in place
  chk_read_state: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN) // [RQ5]
    $past(I_PSEL && !I_PENABLE && !I_PWRITE && I_PADDR == uhcs_pkg::ADDR_CTRL)
    |-> O_PRDATA[uhcs_pkg::FS_LSB +: 2] == $past(ctrl.functional_state))
    else $error("state field read wrong");

  // [RQ12] control write lands the state
  chk_ctrl_write: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN) // [RQ12]
    ctrl_wr |=> ctrl.functional_state == $past(wr_state))
    else $error("state write lost");

  // [RQ13] enable bit follows driver write
  chk_rwe_write: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN) // [RQ13]
    ctrl_wr |=> ctrl.remote_wakeup_enable == $past(I_PWDATA[uhcs_pkg::RWE_BIT]))
    else $error("enable write lost");

  // [RQ10] software reset clears the enable bit
  chk_rwe_swrst: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN) // [RQ10]
    sw_reset |=> !ctrl.remote_wakeup_enable)
    else $error("enable kept over software reset");

  // [RQ4] connected bit follows driver write
  chk_rwc_write: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN) // [RQ4]
    ctrl_wr |=> ctrl.remote_wakeup_connected == $past(I_PWDATA[uhcs_pkg::RWC_BIT]))
    else $error("connected write lost");

  // [RQ4] connected bit holds without a write
  chk_rwc_hold: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN) // [RQ4]
    !ctrl_wr |=> $stable(ctrl.remote_wakeup_connected))
    else $error("connected bit changed by itself");

  // [RQ6] no SOF outside operational
  chk_sof_off: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN) // [RQ6]
    ctrl.functional_state != uhcs_pkg::UHCS_OPERATIONAL |=> !O_SOF_ENABLE)
    else $error("sof enabled outside operational");

  // [RQ6] SOF starts only from operational
  chk_sof_from_op: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN) // [RQ6]
    $rose(sof_running) |-> $past(ctrl.functional_state) == uhcs_pkg::UHCS_OPERATIONAL)
    else $error("sof started outside operational");

  // [RQ7] frame start flag sticky until cleared
  chk_flag_sticky: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN) // [RQ7]
    frame_start_flag && !(ev_wr && I_PWDATA[uhcs_pkg::EV_SOF_BIT]) |=> frame_start_flag)
    else $error("frame start flag dropped");

  // [RQ1] resume in suspend raises the flag
  chk_resume_flag: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN) // [RQ1]
    resume_rise && ctrl.functional_state == uhcs_pkg::UHCS_SUSPENDED |=> resume_flag)
    else $error("resume flag not set");

  // [RQ1] no wake-up while disabled
  chk_wake_off: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN) // [RQ1]
    !ctrl.remote_wakeup_enable |-> !O_REMOTE_WAKEUP)
    else $error("wake-up while disabled");

  // [RQ2] frame start flag reaches the interrupt
  chk_irq_sof: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN) // [RQ2]
    frame_start_flag |-> O_IRQ)
    else $error("interrupt missing with frame start flag");

  // [RQ2] other sources pass through
  chk_irq_ext: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN) // [RQ2]
    I_IRQ_EVENT |-> O_IRQ)
    else $error("external interrupt lost");

  // [RQ2] no interrupt without a source
  chk_irq_quiet: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN) // [RQ2]
    !I_IRQ_EVENT && !resume_flag && !frame_start_flag |-> !O_IRQ)
    else $error("interrupt without a source");

  // [RQ11] hub reset counter keeps moving
  chk_hub_count: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN) // [RQ11]
    O_ROOT_HUB_RESET |=> hub_cnt != 5'h00)
    else $error("hub reset counter stuck");

endmodule

`default_nettype wire

// File: uhcs_partner.sv
// uhcs_partner: downstream device that sends resume signalling on request
// assumes one clock shared with the bench; the line idles low
`timescale 1ns/1ps
`default_nettype none
module uhcs_partner (
  // clock
  input  wire logic i_clk,
  // request from the bench
  input  wire logic i_go,
  // resume signalling toward the detector
  output logic      o_resume
);
  int cnt = 0;
  // downstream resume signalling
  // held for several cycles so it survives the two-flop synchroniser
  always @(posedge i_clk) begin
    if (i_go) begin
      cnt <= 8;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end
  end
  assign o_resume = (cnt > 0);
endmodule
`default_nettype wire

// File: usb_host_control_state_tb_top.sv
// usb_host_control_state_tb_top: self-checking bench for uhcs_top
// assumes zero-wait APB answers and a shortened SOF delay parameter
`timescale 1ns/1ps
`default_nettype none
module usb_host_control_state_tb_top;
  localparam int SOFD = 20;
  logic        clk;
  logic        rst_n;
  logic        psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        irq_ev, irq, wake, sof, hub_rst, res_go, res_det;
  logic [1:0]  fstate;
  int          n_fail, samples_checked;

  uhcs_top #(.SOF_DELAY(SOFD)) dut_u (.I_REF_CLK(clk), .I_RESETN(rst_n), .I_PSEL(psel),
    .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata),
    .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr), .I_RESUME_DETECT(res_det),
    .I_IRQ_EVENT(irq_ev), .O_IRQ(irq), .O_REMOTE_WAKEUP(wake), .O_SOF_ENABLE(sof),
    .O_ROOT_HUB_RESET(hub_rst), .O_FUNCTIONAL_STATE(fstate));
  uhcs_partner part_u (.i_clk(clk), .i_go(res_go), .o_resume(res_det));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // request held until pready is sampled high with psel and penable
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    // only the watchdog ends a stuck wait
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic t_reset;
    chk(hub_rst, 1);
    apb(0, uhcs_pkg::ADDR_CTRL, 0);
    chk(rd, 32'h0);
    chk(fstate, 2'b00);
    cyc(20);
    chk(hub_rst, 0);
    $display("test reset done");
  endtask

  task automatic t_fields;
    for (int s = 0; s < 4; s++) begin
      apb(1, uhcs_pkg::CTRL_WR_CODE == 8'h81 ? uhcs_pkg::ADDR_CTRL : 12'hFFF, 32'hFFFFFF3F | (s << 6));
      apb(0, uhcs_pkg::ADDR_CTRL, 0);
      chk(rd, 32'h600 | (s << 6));
      chk(fstate, s[1:0]);
    end
    apb(1, uhcs_pkg::ADDR_CTRL, 0);
    $display("test fields done");
  endtask

  task automatic t_sof;
    apb(1, uhcs_pkg::ADDR_CTRL, 32'h080);
    cyc(SOFD - 1);
    #1 chk(sof, 0);
    cyc(2);
    #1 chk(sof, 1);
    chk(wake, 0);
    chk(irq, 1);
    apb(0, uhcs_pkg::ADDR_EVENTS, 0);
    chk(rd[1], 1);
    apb(1, uhcs_pkg::ADDR_EVENTS, 32'h3);
    $display("test sof done");
  endtask

  task automatic t_resume;
    int n;
    apb(1, uhcs_pkg::ADDR_CTRL, 32'h6C0);
    cyc(10);
    chk(fstate, 2'b11);
    res_go <= 1'b1;
    @(posedge clk);
    res_go <= 1'b0;
    n = 0;
    while (fstate !== 2'b01 && n < 30) begin
      @(posedge clk);
      n++;
    end
    #1 chk(fstate, 2'b01);
    chk(wake, 1);
    apb(0, uhcs_pkg::ADDR_CTRL, 0);
    chk(rd, 32'h640);
    apb(0, uhcs_pkg::ADDR_EVENTS, 0);
    chk(rd[0], 1);
    apb(1, uhcs_pkg::ADDR_CTRL, 32'h240);
    #1 chk(wake, 0);
    chk(irq, 1);
    $display("test resume done");
  endtask

  task automatic t_resets;
    apb(1, uhcs_pkg::ADDR_SWRESET, 32'h1);
    apb(0, uhcs_pkg::ADDR_CTRL, 0);
    chk(rd, 32'h200);
    @(posedge clk);
    rst_n <= 1'b0;
    cyc(3);
    rst_n <= 1'b1;
    apb(0, uhcs_pkg::ADDR_CTRL, 0);
    chk(rd, 32'h0);
    chk(hub_rst, 1);
    chk(irq, 0);
    @(posedge clk);
    irq_ev <= 1'b1;
    #1 chk(irq, 1);
    irq_ev <= 1'b0;
    apb(1, 12'h010, 32'hFFFFFFFF);
    chk(err, 1);
    apb(0, 12'h010, 0);
    chk(rd, 32'h0);
    $display("test resets done");
  endtask

  task automatic end_of_test;
    $display("checks=%0d mismatches=%0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // whole run is under two hundred cycles; this is far beyond it
  initial begin
    #40us;
    n_fail++;
    end_of_test();
  end

  initial begin
    {psel, penable, pwrite, irq_ev, res_go, rst_n} = '0;
    paddr   = '0;
    pwdata  = '0;
    n_fail  = 0;
    samples_checked = 0;
    cyc(3);
    rst_n <= 1'b1;
    t_reset();
    t_fields();
    t_sof();
    t_resume();
    t_resets();
    end_of_test();
  end
endmodule
`default_nettype wire
